// File: bench/pmc_core_model.sv
// Behavioural core, interrupt and reset source model facing the power block
`timescale 1ns/1ps
module pmc_core_model (
    input  wire logic                        ref_clk,
    input  wire logic [7:0]                  sfr_rdata,
    input  wire logic                        sfr_rvalid,
    output pmc_pkg::pmc_sfr_req_t            sfr_req,
    output logic [pmc_pkg::PMC_IRQ_W-1:0]    irq_pending,
    output logic [pmc_pkg::PMC_IRQ_W-1:0]    irq_enable,
    output logic                             ext_rst_n,
    output logic                             watchdog_timer_rst,
    output logic                             missing_clock_detector_en
);
    import pmc_pkg::*;
    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    initial begin
        sfr_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h78, wdata: 8'h00, insn_done: 1'b0};
        irq_pending = '0;
        irq_enable = '0;
        ext_rst_n = 1'b1;
        watchdog_timer_rst = 1'b0;
        missing_clock_detector_en = 1'b0;
    end
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask
    // Released address and data flip so stale values never match
    task automatic sfr_wr(input logic [7:0] d, input logic done);
        step;
        sfr_req.wr = 1'b1;
        sfr_req.addr = PMC_PCR_ADDR;
        sfr_req.wdata = d;
        sfr_req.insn_done = done;
        step;
        sfr_req.wr = 1'b0;
        sfr_req.insn_done = 1'b0;
        sfr_req.addr = ~PMC_PCR_ADDR;
        sfr_req.wdata = ~d;
    endtask
    // Retire of the two-byte follower instruction
    task automatic retire;
        step;
        sfr_req.insn_done = 1'b1;
        step;
        sfr_req.insn_done = 1'b0;
    endtask
    task automatic sfr_rd(output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        step;
        sfr_req.rd = 1'b1;
        sfr_req.addr = PMC_PCR_ADDR;
        step;
        sfr_req.rd = 1'b0;
        sfr_req.addr = ~PMC_PCR_ADDR;
        for (int i = 0; i < 3 && !ok; i++) begin
            if (sfr_rvalid === 1'b1) begin
                ok = 1'b1;
                d = sfr_rdata;
            end else begin
                step;
            end
        end
    endtask
    task automatic set_irq(input logic [PMC_IRQ_W-1:0] p, input logic [PMC_IRQ_W-1:0] e);
        step;
        irq_pending = p;
        irq_enable = e;
    endtask
    // Detector left on only for short sleeps; analog parts already off
    task automatic set_rst(input logic pin_n, input logic dog, input logic det);
        step;
        ext_rst_n = pin_n;
        watchdog_timer_rst = dog;
        missing_clock_detector_en = det;
    endtask
endmodule

// File: bench/tb.sv
// Self-checking testbench of the power mode control block
`timescale 1ns/1ps
module tb;
    import pmc_pkg::*;
    localparam int DET_SIM = 8;
    logic                  ref_clk;
    logic                  sys_rst;
    pmc_sfr_req_t          sfr_req;
    logic [7:0]            sfr_rdata;
    logic                  sfr_rvalid;
    logic [PMC_IRQ_W-1:0]  irq_pending;
    logic [PMC_IRQ_W-1:0]  irq_enable;
    logic                  ext_rst_n;
    logic                  watchdog_timer_rst;
    logic                  missing_clock_detector_en;
    logic                  cpu_clk_en;
    logic                  periph_clk_en;
    logic                  osc_en;
    logic                  core_rst;
    logic [15:0]           reset_vector;
    logic                  idle_wake_irq;
    logic                  baud_doubler;
    logic [PMC_FLAG_W-1:0] general_flags;
    pmc_mode_t             mode;
    int                    err_total;
    int                    samples_checked;
    int                    cyc;
    logic [7:0]            rd;
    logic                  ok;
    pmc_top #(.IRQ_W(PMC_IRQ_W), .DET_CYC(DET_SIM)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .irq_pending(irq_pending),
        .irq_enable(irq_enable), .ext_rst_n(ext_rst_n), .watchdog_timer_rst(watchdog_timer_rst),
        .missing_clock_detector_en(missing_clock_detector_en),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en), .core_rst(core_rst),
        .reset_vector(reset_vector), .idle_wake_irq(idle_wake_irq), .baud_doubler(baud_doubler),
        .general_flags(general_flags), .mode(mode));
    pmc_core_model core (.ref_clk(ref_clk), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
        .sfr_req(sfr_req), .irq_pending(irq_pending), .irq_enable(irq_enable), .ext_rst_n(ext_rst_n),
        .watchdog_timer_rst(watchdog_timer_rst), .missing_clock_detector_en(missing_clock_detector_en));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Generous ceiling; the whole run needs about 125 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report;
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic read_exp(input logic [7:0] exp);
        core.sfr_rd(rd, ok);
        check({15'h0, ok}, 16'h1, "read answer");
        check({8'h0, rd}, {8'h0, exp}, "read data");
    endtask
    task automatic wait_rst(input int n);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            core.step;
            ok = (core_rst === 1'b1);
        end
        check({15'h0, ok}, 16'h1, "core reset pulse");
        core.step;
        check({14'h0, mode}, {14'h0, PMC_RUN}, "mode run after reset");
        check(reset_vector, 16'h0000, "reset vector");
        read_exp(8'h00);
        // Release, then let the two-flop reset path drain before any new request
        core.set_rst(1'b1, 1'b0, 1'b0);
        repeat (3) core.step;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_flags;
        core.sfr_wr(8'hfc, 1'b1);
        read_exp(8'hfc);
        check({15'h0, baud_doubler}, 16'h1, "baud on");
        check({11'h0, general_flags}, 16'h1f, "flags set");
        core.sfr_wr(8'h54, 1'b1);
        read_exp(8'h54);
        check({15'h0, baud_doubler}, 16'h0, "baud off");
        check({11'h0, general_flags}, 16'h15, "flags mix");
        $display("test flags done");
    endtask
    task automatic t_idle_irq;
        core.sfr_wr(8'h29, 1'b0);
        check({14'h0, mode}, {14'h0, PMC_RUN}, "no idle before retire");
        read_exp(8'h28);
        core.retire;
        check({14'h0, mode}, {14'h0, PMC_IDLE}, "idle entered");
        check({13'h0, cpu_clk_en, periph_clk_en, osc_en}, 16'h3, "idle clocks");
        core.set_irq(16'h0100, 16'h0001);
        repeat (6) core.step;
        check({14'h0, mode}, {14'h0, PMC_IDLE}, "masked irq keeps idle");
        core.set_irq(16'h0100, 16'h0100);
        ok = 1'b0;
        for (int i = 0; i < 5 && !ok; i++) begin
            core.step;
            ok = (idle_wake_irq === 1'b1);
        end
        check({15'h0, ok}, 16'h1, "wake pulse");
        check({14'h0, mode}, {14'h0, PMC_RUN}, "run after wake");
        check({15'h0, cpu_clk_en}, 16'h1, "cpu clock back");
        core.set_irq(16'h0000, 16'h0000);
        read_exp(8'h28);
        $display("test idle interrupt done");
    endtask
    task automatic t_idle_rst(input logic use_dog);
        core.sfr_wr(8'h11, 1'b1);
        check({14'h0, mode}, {14'h0, PMC_IDLE}, "idle entered");
        core.set_rst(use_dog, use_dog, 1'b0);
        wait_rst(10);
        $display("test idle reset done");
    endtask
    task automatic t_stop(input logic det);
        core.set_rst(1'b1, 1'b0, det);
        core.sfr_wr(8'h03, 1'b1);
        check({14'h0, mode}, {14'h0, PMC_STOP}, "stop wins");
        check({13'h0, cpu_clk_en, periph_clk_en, osc_en}, 16'h0, "stop clocks");
        core.set_irq(16'hffff, 16'hffff);
        core.sfr_wr(8'h80, 1'b1);
        check({15'h0, baud_doubler}, 16'h0, "write refused in stop");
        if (det) begin
            wait_rst(DET_SIM + 8);
        end else begin
            repeat (DET_SIM + 8) core.step;
            check({14'h0, mode}, {14'h0, PMC_STOP}, "irq ignored in stop");
            core.set_rst(1'b0, 1'b0, 1'b0);
            wait_rst(10);
        end
        core.set_irq(16'h0000, 16'h0000);
        $display("test stop done");
    endtask
    initial begin
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        sys_rst = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1;
        check({15'h0, core_rst}, 16'h1, "core reset held");
        sys_rst = 1'b0;
        core.step;
        check({13'h0, cpu_clk_en, periph_clk_en, osc_en}, 16'h7, "clocks after reset");
        read_exp(8'h00);
        t_flags;
        t_idle_irq;
        t_idle_rst(1'b0);
        t_idle_rst(1'b1);
        t_stop(1'b0);
        t_stop(1'b1);
        final_report;
    end
endmodule

// File: rtl/pmc_pkg.sv
// Package of constants and carriers for the power mode control block
package pmc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PMC_PCR_ADDR    = 8'h87;
    localparam logic [7:0] PMC_PCR_RESET   = 8'h00;
    localparam int         PMC_IDLE_BIT    = 0;
    localparam int         PMC_STOP_BIT    = 1;
    localparam int         PMC_FLAG_LO     = 2;
    localparam int         PMC_FLAG_HI     = 6;
    localparam int         PMC_BAUD_BIT    = 7;
    localparam int         PMC_FLAG_W      = 5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         PMC_CLK_NS      = 100;
    localparam int         PMC_DET_US      = 100;
    localparam int         PMC_DET_CYC     = (PMC_DET_US * 1000) / PMC_CLK_NS;
    localparam int         PMC_IRQ_W       = 16;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       insn_done;
    } pmc_sfr_req_t;

    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_STOP
    } pmc_mode_t;

endpackage

// File: rtl/pmc_sync.sv
// Two-flop synchroniser for asynchronous reset sources
`timescale 1ns/1ps
module pmc_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic meta;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// File: rtl/pmc_top.sv
// Power mode control: idle and stop modes, power control register
`timescale 1ns/1ps

module pmc_top #(
    parameter int IRQ_W   = pmc_pkg::PMC_IRQ_W,
    parameter int DET_CYC = pmc_pkg::PMC_DET_CYC
) (
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    input  wire pmc_pkg::pmc_sfr_req_t      sfr_req,
    output logic [7:0]                      sfr_rdata,
    output logic                            sfr_rvalid,
    input  wire logic [IRQ_W-1:0]           irq_pending,
    input  wire logic [IRQ_W-1:0]           irq_enable,
    input  wire logic                       ext_rst_n,
    input  wire logic                       watchdog_timer_rst,
    input  wire logic                       missing_clock_detector_en,
    output logic                            cpu_clk_en,
    output logic                            periph_clk_en,
    output logic                            osc_en,
    output logic                            core_rst,
    output logic [15:0]                     reset_vector,
    output logic                            idle_wake_irq,
    output logic                            baud_doubler,
    output logic [pmc_pkg::PMC_FLAG_W-1:0]  general_flags,
    output pmc_pkg::pmc_mode_t              mode
);
    import pmc_pkg::*;

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    logic ext_rst_s;
    logic watchdog_rst_s;
    logic wake;

    pmc_sync u_ext_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (~ext_rst_n),
        .dout    (ext_rst_s)
    );

    pmc_sync u_dog_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (watchdog_timer_rst),
        .dout    (watchdog_rst_s)
    );

    pmc_wake #(
        .IRQ_W (IRQ_W)
    ) u_wake (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .irq_pending (irq_pending),
        .irq_enable  (irq_enable),
        .wake        (wake)
    );

    // ----------------------------------------------------------------
    // Missing clock detector model
    // ----------------------------------------------------------------
    // The real detector sees the oscillator die; here stop time is
    // counted and the timeout stands in for the detection.
    logic [31:0] det_cnt;
    logic [31:0] next_det_cnt;
    logic        det_fire;

    always_comb begin
        next_det_cnt = 32'h0;
        if (mode == PMC_STOP && missing_clock_detector_en && !det_fire) begin
            next_det_cnt = det_cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            det_cnt <= 32'h0;
        end else begin
            det_cnt <= next_det_cnt;
        end
    end

    assign det_fire = (mode == PMC_STOP) && missing_clock_detector_en && (det_cnt >= 32'(DET_CYC - 1));

    // ----------------------------------------------------------------
    // Register and mode state
    // ----------------------------------------------------------------
    logic                  any_rst;
    logic                  pcr_wr;
    logic                  idle_req;
    logic                  stop_req;
    pmc_mode_t             next_mode;
    logic                  next_baud;
    logic [PMC_FLAG_W-1:0] next_flags;
    logic                  next_idle_req;
    logic                  next_stop_req;
    logic                  next_wake_irq;
    logic                  next_core_rst;
    logic [7:0]            next_rdata;
    logic                  next_rvalid;

    assign any_rst = ext_rst_s | watchdog_rst_s | det_fire;
    assign pcr_wr  = sfr_req.wr && (sfr_req.addr == PMC_PCR_ADDR);

    always_comb begin
        next_mode     = mode;
        next_baud     = baud_doubler;
        next_flags    = general_flags;
        next_idle_req = idle_req;
        next_stop_req = stop_req;
        next_wake_irq = 1'b0;
        next_core_rst = 1'b0;
        next_rvalid   = sfr_req.rd && (sfr_req.addr == PMC_PCR_ADDR);
        next_rdata    = 8'h00;
        if (next_rvalid) begin
            next_rdata[PMC_BAUD_BIT]          = baud_doubler;
            next_rdata[PMC_FLAG_HI:PMC_FLAG_LO] = general_flags;
            // Select bits never read back
        end
        if (pcr_wr && mode == PMC_RUN) begin
            next_baud     = sfr_req.wdata[PMC_BAUD_BIT];
            next_flags    = sfr_req.wdata[PMC_FLAG_HI:PMC_FLAG_LO];
            next_idle_req = sfr_req.wdata[PMC_IDLE_BIT];
            next_stop_req = sfr_req.wdata[PMC_STOP_BIT];
        end
        case (mode)
            PMC_RUN: begin
                // Entry waits for the writing instruction to retire
                if (sfr_req.insn_done && (next_stop_req || next_idle_req)) begin
                    next_mode     = next_stop_req ? PMC_STOP : PMC_IDLE;
                    next_idle_req = 1'b0;
                    next_stop_req = 1'b0;
                end
            end
            PMC_IDLE: begin
                if (any_rst) begin
                    next_mode     = PMC_RUN;
                    next_core_rst = 1'b1;
                end else if (wake) begin
                    next_mode     = PMC_RUN;
                    next_wake_irq = 1'b1;
                end
            end
            PMC_STOP: begin
                // Interrupts ignored here; only resets leave
                if (any_rst) begin
                    next_mode     = PMC_RUN;
                    next_core_rst = 1'b1;
                end
            end
            default: begin
                next_mode = PMC_RUN;
            end
        endcase
        if (mode == PMC_RUN && any_rst) begin
            // Reset wins over a retiring entry; the core must not sleep mid-reset
            next_mode     = PMC_RUN;
            next_core_rst = 1'b1;
            next_idle_req = 1'b0;
            next_stop_req = 1'b0;
        end
        if (next_core_rst) begin
            next_baud  = 1'b0;
            next_flags = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode          <= PMC_RUN;
            baud_doubler  <= 1'b0;
            general_flags <= '0;
            idle_req      <= 1'b0;
            stop_req      <= 1'b0;
            idle_wake_irq <= 1'b0;
            core_rst      <= 1'b1;
            sfr_rdata     <= PMC_PCR_RESET;
            sfr_rvalid    <= 1'b0;
        end else begin
            mode          <= next_mode;
            baud_doubler  <= next_baud;
            general_flags <= next_flags;
            idle_req      <= next_idle_req;
            stop_req      <= next_stop_req;
            idle_wake_irq <= next_wake_irq;
            core_rst      <= next_core_rst;
            sfr_rdata     <= next_rdata;
            sfr_rvalid    <= next_rvalid;
        end
    end

    // ----------------------------------------------------------------
    // Clock gating outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_en        <= 1'b1;
            reset_vector  <= 16'h0000;
        end else begin
            cpu_clk_en    <= (next_mode == PMC_RUN);
            periph_clk_en <= (next_mode != PMC_STOP);
            osc_en        <= (next_mode != PMC_STOP);
            reset_vector  <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_IDLE_WAITS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_RUN && !sfr_req.insn_done) |=> mode == PMC_RUN)
        else $error("Mode left run before instruction completed");

    AST_IDLE_GATES: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_IDLE) |=> (!cpu_clk_en && periph_clk_en) || mode != PMC_IDLE)
        else $error("Idle clock gating wrong");

    AST_WAKE_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_IDLE && wake && !any_rst) |=> (mode == PMC_RUN && idle_wake_irq && cpu_clk_en))
        else $error("Interrupt did not wake idle");

    AST_RST_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_IDLE && any_rst) |=> (core_rst && mode == PMC_RUN && reset_vector == 16'h0000))
        else $error("Reset did not end idle");

    AST_DOG_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_IDLE && watchdog_rst_s) |=> core_rst)
        else $error("Watchdog did not reset in idle");

    AST_STOP_NO_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_STOP && !any_rst) |=> (mode == PMC_STOP && !osc_en))
        else $error("Stop left without reset");

    AST_DET_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
        det_fire |=> (mode == PMC_RUN && core_rst))
        else $error("Detector did not end stop");

    AST_SEL_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sfr_rvalid |-> sfr_rdata[1:0] == 2'b00)
        else $error("Select bits read nonzero");

    AST_FLAG_WR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (pcr_wr && mode == PMC_RUN && !any_rst) |=> general_flags == $past(sfr_req.wdata[PMC_FLAG_HI:PMC_FLAG_LO]))
        else $error("Flags not stored");

    AST_BAUD_WR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (pcr_wr && mode == PMC_RUN && !any_rst) |=> baud_doubler == $past(sfr_req.wdata[PMC_BAUD_BIT]))
        else $error("Baud doubler not stored");

    AST_RD_FLAGS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sfr_rvalid |-> sfr_rdata[PMC_FLAG_HI:PMC_FLAG_LO] == $past(general_flags))
        else $error("Flags read back wrong");

    AST_REFUSE_WR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (pcr_wr && mode != PMC_RUN && !any_rst) |=> ($stable(general_flags) && $stable(baud_doubler)))
        else $error("Register changed while asleep");

    AST_STOP_ENTRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_RUN && pcr_wr && sfr_req.wdata[PMC_STOP_BIT] && sfr_req.insn_done && !any_rst) |=> mode == PMC_STOP)
        else $error("Stop not entered");

    AST_STOP_CLKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_STOP) |-> (!cpu_clk_en && !periph_clk_en && !osc_en))
        else $error("Clock running in stop");

    AST_RUN_RST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (mode == PMC_RUN && any_rst) |=> (mode == PMC_RUN && core_rst))
        else $error("Sleep entered during reset");

    AST_RST_CLEARS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        any_rst |=> (general_flags == '0 && !baud_doubler))
        else $error("Register not cleared by reset");

    COV_IDLE_WAKE:  cover property (@(posedge ref_clk) disable iff (sys_rst) mode == PMC_IDLE ##1 idle_wake_irq);
    COV_STOP_DET:   cover property (@(posedge ref_clk) disable iff (sys_rst) det_fire);
    COV_IDLE_DOG:   cover property (@(posedge ref_clk) disable iff (sys_rst) mode == PMC_IDLE && watchdog_rst_s);
    COV_STOP_EXT:   cover property (@(posedge ref_clk) disable iff (sys_rst) mode == PMC_STOP && ext_rst_s);
    COV_REFUSED_WR: cover property (@(posedge ref_clk) disable iff (sys_rst) pcr_wr && mode == PMC_STOP);
endmodule

// File: rtl/pmc_wake.sv
// Wake condition: OR of pending and enabled interrupt requests
`timescale 1ns/1ps
module pmc_wake #(
    parameter int IRQ_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [IRQ_W-1:0] irq_pending,
    input  wire logic [IRQ_W-1:0] irq_enable,
    output logic                  wake
);
    logic next_wake;

    always_comb begin
        next_wake = |(irq_pending & irq_enable);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake <= 1'b0;
        end else begin
            wake <= next_wake;
        end
    end
endmodule
